/* File: src/adcts_pkg.sv */
// Package for the converter timing and input select block: offsets, fields, types.
// Assumes APB with 32-bit data; registers are 16 bits in the low half of a word.
package adcts_pkg;

    // Register byte addresses
    localparam logic [11:0] TIMING_OFS = 12'h000;
    localparam logic [11:0] INSEL_OFS = 12'h004;

    // Implemented-bit masks; all other bits read zero
    localparam logic [15:0] TIMING_MASK = 16'h9fff;
    localparam logic [15:0] INSEL_MASK = 16'h8f8f;
    localparam logic [15:0] REG_RESET = 16'h0000;

    // Timing register fields
    localparam int SRC_BIT = 15;
    localparam int SAMC_LSB = 8;
    localparam int DIV_LSB = 0;
    // Input select register fields
    localparam int NEGB_BIT = 15;
    localparam int POSB_LSB = 8;
    localparam int NEGA_BIT = 7;
    localparam int POSA_LSB = 0;

    // Status word layout
    localparam int STAT_MUXB_BIT = 0;
    localparam int STAT_SAMP_BIT = 1;
    localparam int STAT_CONVCLK_BIT = 2;

    localparam logic [11:0] STATUS_OFS = 12'h008;
    localparam logic [8:0] DIV_ONE = 9'h001;
    localparam logic [4:0] SAMC_ONE = 5'h01;

    // Negative input choice
    typedef enum logic {NEG_VREF, NEG_AN1} adcts_neg_e;

    // Selected sample/hold inputs
    typedef struct packed {
        logic [3:0] pos_sel;
        adcts_neg_e neg_sel;
        logic mux_b;
    } adcts_sel_s;

    // Timing configuration
    typedef struct packed {
        logic clk_src_rc;
        logic [4:0] samc;
        logic [7:0] div;
    } adcts_timing_s;

endpackage

/* File: src/adcts_top.sv */
// Converter timing and input select: conversion clock, auto-sample count, mux A/B select.
// Assumes an APB master on core_clk, an RC oscillator tick input synchronous to core_clk,
// and a sequencer that pulses sample_start and sample_done per sample.
//
// Overview of operation
// - Timing bit 15 picks conversion clock: one for RC, zero for system clock.
// - Five-bit field sets auto-sample length in conversion clock periods, 0 to 31.
// - Eight-bit divider N gives conversion clock period of N+1 instruction cycles.
// - Mux B positive input is the analog input indexed by the four-bit field.
// - Mux A negative input is input 1 when bit set, else negative reference.
// - Unimplemented bits read zero and ignore writes in both registers.
// - Alternate mode uses A first then alternates B and A; otherwise always A.
//
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/10ps
module adcts_top (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Converter control
    input wire logic rc_clk_tick,
    input wire logic alternate_sampling_enable,
    input wire logic sample_start,
    input wire logic sample_done,
    // Conversion clock and sampling
    output logic conv_clk_tick,
    output logic auto_sample_busy,
    output logic auto_sample_end,
    // Sample/hold input selection
    output logic [3:0] ch0_pos_sel,
    output logic ch0_neg_an1,
    output logic ch0_mux_b
);

    // Reset release through two flops
    logic rst_meta_r;
    logic rst_sync_n;
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_meta_r <= 1'b0;
            rst_sync_n <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_sync_n <= rst_meta_r;
        end
    end

    // Register state
    logic [15:0] timing_r, timing_nxt;
    logic [15:0] insel_r, insel_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic pslverr_r, pslverr_nxt;
    logic access;
    logic hit_timing, hit_insel, hit_status;
    adcts_pkg::adcts_timing_s tcfg;
    logic [15:0] status_w;

    // Zero-wait slave: every access completes in its first access cycle
    assign access = psel & penable;
    assign hit_timing = (paddr == adcts_pkg::TIMING_OFS);
    assign hit_insel = (paddr == adcts_pkg::INSEL_OFS);
    assign hit_status = (paddr == adcts_pkg::STATUS_OFS);
    assign pready = 1'b1;
    assign prdata = prdata_r;
    assign pslverr = pslverr_r;

    // Register writes, reads and error answer
    always_comb
    begin
        timing_nxt = timing_r;
        insel_nxt = insel_r;
        prdata_nxt = prdata_r;
        pslverr_nxt = 1'b0;
        if (psel & ~penable)
        begin
            // Read data staged in setup so it is a flop in the access phase
            prdata_nxt = 32'h0000_0000;
            if (!pwrite)
            begin
                if (hit_timing)
                    prdata_nxt = {16'h0000, timing_r};
                else if (hit_insel)
                    prdata_nxt = {16'h0000, insel_r};
                else if (hit_status)
                    prdata_nxt = {16'h0000, status_w};
            end
            pslverr_nxt = ~(hit_timing | hit_insel | (hit_status & ~pwrite));
        end
        if (access & pwrite)
        begin
            if (hit_timing)
                timing_nxt = pwdata[15:0] & adcts_pkg::TIMING_MASK;
            if (hit_insel)
                insel_nxt = pwdata[15:0] & adcts_pkg::INSEL_MASK;
        end
        if (access)
            pslverr_nxt = pslverr_r;
    end

    always_ff @(posedge core_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            timing_r <= adcts_pkg::REG_RESET;
            insel_r <= adcts_pkg::REG_RESET;
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end
        else
        begin
            timing_r <= timing_nxt;
            insel_r <= insel_nxt;
            prdata_r <= prdata_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    // Timing fields
    assign tcfg.clk_src_rc = timing_r[adcts_pkg::SRC_BIT];
    assign tcfg.samc = timing_r[adcts_pkg::SAMC_LSB +: 5];
    assign tcfg.div = timing_r[adcts_pkg::DIV_LSB +: 8];

    // Conversion clock divider; RC source bypasses it
    logic [8:0] div_cnt_r, div_cnt_nxt;
    logic sys_tick;
    always_comb
    begin
        div_cnt_nxt = div_cnt_r + adcts_pkg::DIV_ONE;
        sys_tick = 1'b0;
        if (div_cnt_r >= {1'b0, tcfg.div})
        begin
            div_cnt_nxt = 9'h000;
            sys_tick = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            div_cnt_r <= 9'h000;
        else
            div_cnt_r <= div_cnt_nxt;
    end

    // One tick per conversion clock period
    assign conv_clk_tick = tcfg.clk_src_rc ? rc_clk_tick : sys_tick;

    // Auto-sample counter in conversion clock periods
    typedef enum {SMP_IDLE, SMP_RUN} adcts_smp_e;
    adcts_smp_e smp_r, smp_nxt;
    logic [4:0] smp_cnt_r, smp_cnt_nxt;
    logic smp_end_r, smp_end_nxt;
    always_comb
    begin
        smp_nxt = smp_r;
        smp_cnt_nxt = smp_cnt_r;
        smp_end_nxt = 1'b0;
        case (smp_r)
            SMP_IDLE:
            begin
                if (sample_start)
                begin
                    smp_cnt_nxt = tcfg.samc;
                    // Zero length ends at once; not a useful setting
                    if (tcfg.samc == 5'h00)
                        smp_end_nxt = 1'b1;
                    else
                        smp_nxt = SMP_RUN;
                end
            end
            SMP_RUN:
            begin
                if (conv_clk_tick)
                begin
                    smp_cnt_nxt = smp_cnt_r - adcts_pkg::SAMC_ONE;
                    if (smp_cnt_r == adcts_pkg::SAMC_ONE)
                    begin
                        smp_end_nxt = 1'b1;
                        smp_nxt = SMP_IDLE;
                    end
                end
            end
            default:
                smp_nxt = SMP_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            smp_r <= SMP_IDLE;
            smp_cnt_r <= 5'h00;
            smp_end_r <= 1'b0;
        end
        else
        begin
            smp_r <= smp_nxt;
            smp_cnt_r <= smp_cnt_nxt;
            smp_end_r <= smp_end_nxt;
        end
    end

    assign auto_sample_busy = (smp_r == SMP_RUN);
    assign auto_sample_end = smp_end_r;

    // Mux setting sequencer: A first, toggle after each sample in alternate mode
    logic use_b_r, use_b_nxt;
    always_comb
    begin
        use_b_nxt = use_b_r;
        if (!alternate_sampling_enable)
            use_b_nxt = 1'b0;
        else if (sample_done)
            use_b_nxt = ~use_b_r;
    end

    always_ff @(posedge core_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            use_b_r <= 1'b0;
        else
            use_b_r <= use_b_nxt;
    end

    // Input selection, registered so outputs are glitch free
    adcts_pkg::adcts_sel_s sel_r, sel_nxt;
    always_comb
    begin
        sel_nxt.mux_b = use_b_r;
        if (use_b_r)
        begin
            sel_nxt.pos_sel = insel_r[adcts_pkg::POSB_LSB +: 4];
            sel_nxt.neg_sel = adcts_pkg::adcts_neg_e'(insel_r[adcts_pkg::NEGB_BIT]);
        end
        else
        begin
            sel_nxt.pos_sel = insel_r[adcts_pkg::POSA_LSB +: 4];
            sel_nxt.neg_sel = adcts_pkg::adcts_neg_e'(insel_r[adcts_pkg::NEGA_BIT]);
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            sel_r <= '0;
        else
            sel_r <= sel_nxt;
    end

    assign ch0_pos_sel = sel_r.pos_sel;
    assign ch0_neg_an1 = (sel_r.neg_sel == adcts_pkg::NEG_AN1);
    assign ch0_mux_b = sel_r.mux_b;

    // Read-only status word
    always_comb
    begin
        status_w = 16'h0000;
        status_w[adcts_pkg::STAT_MUXB_BIT] = use_b_r;
        status_w[adcts_pkg::STAT_SAMP_BIT] = auto_sample_busy;
        status_w[adcts_pkg::STAT_CONVCLK_BIT] = tcfg.clk_src_rc;
    end

endmodule

/* File: bench/adcts_asserts.sv */
// Checker for the converter timing and select block.
// Assumes it is bound to adcts_top and sees its ports only.
`timescale 1ns/10ps
module adcts_asserts (
    // Clock, reset, APB
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    // Converter side
    input wire logic rc_clk_tick,
    input wire logic alternate_sampling_enable,
    input wire logic sample_start,
    input wire logic sample_done,
    input wire logic conv_clk_tick,
    input wire logic auto_sample_busy,
    input wire logic auto_sample_end,
    input wire logic ch0_mux_b
);
    logic [15:0] tm_r;
    logic [15:0] tm_nxt;
    // Shadow of the timing register, taken from completed writes
    always_comb
    begin
        tm_nxt = tm_r;
        if (psel && penable && pwrite && paddr == adcts_pkg::TIMING_OFS)
            tm_nxt = pwdata[15:0];
    end
    always_ff @(posedge core_clk or negedge rst_n)
        if (!rst_n)
            tm_r <= 16'h0;
        else
            tm_r <= tm_nxt;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_end_once: assert property (auto_sample_end |=> !auto_sample_end)
        else $error("sample end longer than one cycle");
    a_end_idle: assert property (auto_sample_end |-> !auto_sample_busy)
        else $error("busy still high at sample end");
    a_zero_len: assert property (sample_start && !auto_sample_busy && tm_r[12:8] == 5'h0 |=> auto_sample_end)
        else $error("zero length sample did not end");
    a_busy_start: assert property (sample_start && !auto_sample_busy && tm_r[12:8] != 5'h0 |=> auto_sample_busy)
        else $error("sampling did not start");
    a_rc_follow: assert property (tm_r[15] |-> conv_clk_tick == rc_clk_tick)
        else $error("conversion tick not from RC source");
    a_div_one: assert property (!tm_r[15] && tm_r[7:0] == 8'h0 |-> conv_clk_tick)
        else $error("divider zero must tick every cycle");
    a_alt_off: assert property (!alternate_sampling_enable |-> ##2 !ch0_mux_b)
        else $error("setting B used with alternation off");
    a_alt_flip: assert property (alternate_sampling_enable && sample_done |-> ##2 ch0_mux_b != $past(ch0_mux_b))
        else $error("setting did not alternate");
    // Main scenarios, the longest interval among them
    cover property (sample_start ##1 auto_sample_busy);
    cover property (auto_sample_end && tm_r[12:8] == 5'h1f);
    cover property (ch0_mux_b);
endmodule
bind adcts_top adcts_asserts i_adcts_asserts (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .rc_clk_tick(rc_clk_tick), .sample_start(sample_start),
    .alternate_sampling_enable(alternate_sampling_enable), .sample_done(sample_done), .conv_clk_tick(conv_clk_tick),
    .auto_sample_busy(auto_sample_busy), .auto_sample_end(auto_sample_end), .ch0_mux_b(ch0_mux_b));

/* File: bench/adcts_tb_top.sv */
// Self-checking bench for adcts_top over APB.
// Assumes outputs read just after an edge show the values sampled there.
`timescale 1ns/10ps
module adcts_tb_top;
    logic core_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, rc = 1'b0, alt = 1'b0, start = 1'b0, done = 1'b0;
    logic tick, busy, send, neg, mux;
    logic [3:0] pos;
    int errors = 0, checks_done = 0, n;
    always #20 core_clk = ~core_clk;
    adcts_top i_adcts_top (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rc_clk_tick(rc),
        .alternate_sampling_enable(alt), .sample_start(start), .sample_done(done), .conv_clk_tick(tick),
        .auto_sample_busy(busy), .auto_sample_end(send), .ch0_pos_sel(pos), .ch0_neg_an1(neg), .ch0_mux_b(mux));
    task test_done;
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task ck;
        @(posedge core_clk);
    endtask
    // Bounded wait ran out: count it and stop
    task bail;
        errors++;
        test_done;
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        ck;
        penable <= 1'h1;
        ck;
        for (n = 1; pready !== 1'h1 && n < 50; n++)
            ck;
        if (n >= 50)
            bail;
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        ck; // Idle edge keeps psel from two writes in one step
    endtask
    // Edges until the next conversion tick
    task wtick;
        ck;
        for (n = 1; tick !== 1'h1 && n < 300; n++)
            ck;
        if (n >= 300)
            bail;
    endtask
    task t_regs;
        apb(1'h0, adcts_pkg::INSEL_OFS, 32'h0);
        chk("insel reset", rd, 32'h0);
        apb(1'h1, adcts_pkg::TIMING_OFS, 32'hffff_ff00); // Divider kept at zero
        apb(1'h0, adcts_pkg::TIMING_OFS, 32'h0);
        chk("timing", rd, 32'h9f00);
        chk("timing err", err, 1'h0);
        // Status shows the RC source just selected; it refuses writes
        apb(1'h0, adcts_pkg::STATUS_OFS, 32'h0);
        chk("status src", rd, 32'h1 << adcts_pkg::STAT_CONVCLK_BIT);
        apb(1'h1, adcts_pkg::STATUS_OFS, 32'h0);
        chk("status write err", err, 1'h1);
        apb(1'h1, adcts_pkg::INSEL_OFS, 32'hffff_ffff);
        apb(1'h0, adcts_pkg::INSEL_OFS, 32'h0);
        chk("insel", rd, 32'h8f8f);
        apb(1'h0, 12'h00c, 32'h0);
        chk("unmapped err", err, 1'h1);
        chk("unmapped data", rd, 32'h0);
        apb(1'h1, adcts_pkg::TIMING_OFS, 32'h0);
        $display("t_regs done");
    endtask
    task t_div;
        int v[4] = '{0, 1, 7, 255};
        foreach (v[i])
        begin
            apb(1'h1, adcts_pkg::TIMING_OFS, v[i]);
            wtick;
            wtick;
            chk("period", n, v[i] + 1);
        end
        $display("t_div done");
    endtask
    task t_samp;
        int v[4] = '{0, 1, 5, 31};
        foreach (v[i])
        begin
            apb(1'h1, adcts_pkg::TIMING_OFS, 32'h8000 | (v[i] << 8));
            start <= 1'h1;
            ck;
            start <= 1'h0;
            ck;
            if (v[i] == 0)
                chk("end zero", send, 1'h1);
            else
            begin
                chk("busy", busy, 1'h1);
                repeat (v[i])
                begin
                    rc <= 1'h1;
                    ck;
                    rc <= 1'h0;
                    chk("rc tick", tick, 1'h1);
                    chk("early end", send, 1'h0);
                    ck;
                end
                chk("end", send, 1'h1);
                chk("busy off", busy, 1'h0);
            end
            ck;
            chk("end once", send, 1'h0);
        end
        apb(1'h1, adcts_pkg::TIMING_OFS, 32'h0);
        $display("t_samp done");
    endtask
    // Optional sample end, then the settled selection
    task step(input logic d, input logic [3:0] p, input logic ng, input logic m);
        done <= d;
        ck;
        done <= 1'h0;
        repeat (4) ck;
        chk("pos", pos, p);
        chk("neg", neg, ng);
        chk("mux", mux, m);
    endtask
    task t_mux;
        apb(1'h1, adcts_pkg::INSEL_OFS, 32'h8a05);
        step(1'h1, 4'h5, 1'h0, 1'h0);
        alt <= 1'h1;
        step(1'h1, 4'ha, 1'h1, 1'h1);
        apb(1'h0, adcts_pkg::STATUS_OFS, 32'h0);
        chk("status mux", rd, 32'h1 << adcts_pkg::STAT_MUXB_BIT);
        step(1'h1, 4'h5, 1'h0, 1'h0);
        apb(1'h1, adcts_pkg::INSEL_OFS, 32'h0f83);
        step(1'h0, 4'h3, 1'h1, 1'h0);
        step(1'h1, 4'hf, 1'h0, 1'h1);
        alt <= 1'h0;
        step(1'h0, 4'h3, 1'h1, 1'h0);
        $display("t_mux done");
    endtask
    initial
    begin
        repeat (3) ck;
        rst_n <= 1'h1;
        repeat (3) ck;
        t_regs;
        t_div;
        t_samp;
        t_mux;
        test_done;
    end
endmodule
